/* File: design/ssg_defs.svh */
// Constants for the SCSI selection and general command sequencer.
// Assumes a 100 MHz REF_CLK and AHB-Lite word access to the register file.
`ifndef SSG_DEFS_SVH
`define SSG_DEFS_SVH

// Register byte offsets
`define SSG_OFS_FIFO 8'h00
`define SSG_OFS_CMD 8'h04
`define SSG_OFS_STAT 8'h08
`define SSG_OFS_STIM 8'h0c
`define SSG_OFS_CTL1 8'h10
`define SSG_OFS_DEST 8'h14
`define SSG_OFS_STC 8'h18
`define SSG_OFS_CTC 8'h1c
`define SSG_OFS_FLAGS 8'h20
`define SSG_OFS_STATE 8'h24

// Command codes, bit 7 is the DMA flag
`define SSG_CMD_DMA_BIT 7
`define SSG_CMD_NOP 7'h00
`define SSG_CMD_CLRF 7'h01
`define SSG_CMD_XFER 7'h10
`define SSG_CMD_SELA 7'h42
`define SSG_CMD_SELS 7'h43
`define SSG_CMD_ENSEL 7'h44
`define SSG_CMD_DISSEL 7'h45
`define SSG_CMD_SEL3 7'h46

// Interrupt status bits
`define SSG_INT_SUCC 0
`define SSG_INT_SREQ 1
`define SSG_INT_INV 2
`define SSG_INT_DISC 3
`define SSG_INT_SELD 4
`define SSG_INT_RESEL 5

// SCSI control line indices
`define SSG_BSY 0
`define SSG_SEL 1
`define SSG_ATN 2
`define SSG_ACK 3
`define SSG_REQ 4
`define SSG_MSG 5
`define SSG_CD 6
`define SSG_IO 7

// Phases as {MSG, C/D, I/O}
`define SSG_PH_MSGOUT 3'b110
`define SSG_PH_CMD 3'b010

// Timing
`define SSG_CLK_NS 10
`define SSG_ARB_NS 2400
`define SSG_SETTLE_NS 90
`define SSG_FLUSH_CYC 3
`define SSG_ARB_CYC ((`SSG_ARB_NS + `SSG_CLK_NS - 1) / `SSG_CLK_NS)
`define SSG_SETTLE_CYC ((`SSG_SETTLE_NS + `SSG_CLK_NS - 1) / `SSG_CLK_NS)
`define SSG_FIFO_DEPTH 16

`endif

/* File: design/ssg_pkg.sv */
// Types for the SCSI selection and general command sequencer.
// Assumes the constants header is compiled alongside.
package ssg_pkg;
   typedef enum logic [3:0] {
      S_IDLE, S_ARBW, S_ARB, S_SELD, S_SELW, S_XREQ, S_XACK, S_CONN, S_RESP
   } ssg_state_e;
   typedef logic [7:0] ssg_byte_t;
endpackage : ssg_pkg

/* File: design/ssg_top.sv */
// SCSI initiator selection sequencer and general commands behind AHB-Lite.
// Assumes open-drain SCSI pins resolved outside and a single-master bus.
//
// The implementer's own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ns
`include "ssg_defs.svh"
module ssg_top #(
   parameter int TICK_CYC = 8192 // Cycles per selection-timeout unit
) (
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic SRST,
   // AHB-Lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // SCSI control lines, active low, open drain
   input wire logic [7:0] SCSI_CTL_IN,
   output logic [7:0] SCSI_CTL_OUT,
   output logic [7:0] SCSI_CTL_OE_N,
   // SCSI data bus, active low
   input wire logic [7:0] SCSI_DB_IN,
   output logic [7:0] SCSI_DB_OUT,
   output logic SCSI_DB_OE_N,
   // Received bytes toward buffer memory
   output logic DMA_RX_VALID,
   output logic [7:0] DMA_RX_DATA
);
   ssg_pkg::ssg_state_e st_reg, st_next;
   logic [7:0] ctl_s1_reg, ctl_s2_reg, db_s1_reg, db_s2_reg, ctl, dbi;
   logic [7:0] mem [0:`SSG_FIFO_DEPTH-1];
   logic [3:0] wp_reg, wp_next, rp_reg, rp_next;
   logic [4:0] fcnt_reg, fcnt_next;
   logic [31:0] hr_reg, hr_next;
   logic wpend_reg, wpend_next, cvld_reg, cvld_next;
   logic [7:0] wa_reg, wa_next, cmd_reg, cmd_next, stim_reg, stim_next, ctl1_reg, ctl1_next;
   logic [7:0] dest_reg, dest_next;
   logic [15:0] stc_reg, stc_next, ctc_reg, ctc_next, tick_reg, tick_next;
   logic [5:0] int_reg, int_next, int_set, int_clr;
   logic host_push, host_pop, push_ok, pop_ok, mem_we;
   logic [7:0] cnt_reg, cnt_next, tmo_reg, tmo_next, oe_reg, oe_next, dbo_reg, dbo_next, dmad_reg, dmad_next;
   logic [1:0] msg_reg, msg_next;
   logic dboe_reg, dboe_next, armed_reg, armed_next, stop_reg, stop_next, ti_reg, ti_next;
   logic resel_reg, resel_next, dmav_reg, dmav_next;
   logic cmd_take, clr_req, seq_pop, seq_push, tick, sel_det, disc, cmd_ok, exp_msg;
   logic [6:0] op;
   logic [7:0] own_bit, higher;
   logic [2:0] phase;

   // Pin inputs pass two flops; lines are active low at the pins
   always_ff @(posedge REF_CLK) begin
      ctl_s1_reg <= SCSI_CTL_IN;
      ctl_s2_reg <= ctl_s1_reg;
      db_s1_reg <= SCSI_DB_IN;
      db_s2_reg <= db_s1_reg;
   end
   assign ctl = ~ctl_s2_reg;
   assign dbi = ~db_s2_reg;
   assign phase = {ctl[`SSG_MSG], ctl[`SSG_CD], ctl[`SSG_IO]};
   assign own_bit = 8'h01 << ctl1_reg[2:0];
   assign higher = ~((own_bit << 1) - 8'h01);
   assign tick = (tick_reg == 16'(TICK_CYC - 1));
   assign op = cmd_reg[6:0];
   assign exp_msg = (msg_reg != 2'h0) || ti_reg;
   // Bus-initiated selection only while armed and idle
   assign sel_det = armed_reg && ctl[`SSG_SEL] && !ctl[`SSG_BSY] && ((dbi & own_bit) != 8'h00);
   assign disc = !ctl[`SSG_BSY] && oe_reg[`SSG_BSY];
   assign cmd_ok = cvld_reg && ((st_reg == ssg_pkg::S_IDLE && !sel_det) || (st_reg == ssg_pkg::S_CONN && !disc));

   // Register file, AHB-Lite slave and byte FIFO
   always_comb begin
      hr_next = 32'h0000_0000;
      wpend_next = 1'b0;
      wa_next = wa_reg;
      cmd_next = cmd_reg;
      cvld_next = cvld_reg && !cmd_take;
      stim_next = stim_reg;
      ctl1_next = ctl1_reg;
      dest_next = dest_reg;
      stc_next = stc_reg;
      int_clr = 6'h00;
      host_push = 1'b0;
      host_pop = 1'b0;
      // Reads answer from the address phase so data stands registered
      if (HSEL && HREADY && HTRANS[1]) begin
         if (HWRITE) begin
            wpend_next = 1'b1;
            wa_next = HADDR[7:0];
         end else begin
            case (HADDR[7:0])
               `SSG_OFS_FIFO: begin
                  hr_next = {24'h000000, mem[rp_reg]};
                  host_pop = 1'b1;
               end
               `SSG_OFS_CMD: hr_next = {24'h000000, cmd_reg};
               `SSG_OFS_STAT: begin
                  hr_next = {26'h0000000, int_reg};
                  int_clr = 6'h3f;
               end
               `SSG_OFS_STIM: hr_next = {24'h000000, stim_reg};
               `SSG_OFS_CTL1: hr_next = {24'h000000, ctl1_reg};
               `SSG_OFS_DEST: hr_next = {24'h000000, dest_reg};
               `SSG_OFS_STC: hr_next = {16'h0000, stc_reg};
               `SSG_OFS_CTC: hr_next = {16'h0000, ctc_reg};
               `SSG_OFS_FLAGS: hr_next = {27'h0000000, fcnt_reg};
               `SSG_OFS_STATE: hr_next = {23'h000000, armed_reg, 4'h0, 4'(st_reg)};
               default: hr_next = 32'h0000_0000;
            endcase
         end
      end
      if (wpend_reg) begin
         case (wa_reg)
            `SSG_OFS_FIFO: host_push = 1'b1;
            `SSG_OFS_CMD: begin
               cmd_next = HWDATA[7:0];
               cvld_next = 1'b1;
            end
            `SSG_OFS_STIM: stim_next = HWDATA[7:0];
            `SSG_OFS_CTL1: ctl1_next = HWDATA[7:0];
            `SSG_OFS_DEST: dest_next = HWDATA[7:0];
            `SSG_OFS_STC: stc_next = HWDATA[15:0];
            default: ;
         endcase
      end
      // Held reset while answering a bus-initiated selection
      if (st_reg == ssg_pkg::S_RESP) begin
         cmd_next = 8'h00;
         cvld_next = 1'b0;
      end
      // A flag set in the same cycle as its read survives
      int_next = (int_reg & ~int_clr) | int_set;
      // Sequencer push wins over a host push in the same cycle
      push_ok = (seq_push || host_push) && (fcnt_reg != 5'(`SSG_FIFO_DEPTH));
      pop_ok = (seq_pop || host_pop) && (fcnt_reg != 5'h00);
      mem_we = push_ok && !clr_req;
      if (clr_req) begin
         wp_next = 4'h0;
         rp_next = 4'h0;
         fcnt_next = 5'h00;
      end else begin
         wp_next = push_ok ? wp_reg + 4'h1 : wp_reg;
         rp_next = pop_ok ? rp_reg + 4'h1 : rp_reg;
         fcnt_next = fcnt_reg + {4'h0, push_ok} - {4'h0, pop_ok};
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         hr_reg <= 32'h0000_0000;
         wpend_reg <= 1'b0;
         wa_reg <= 8'h00;
         cmd_reg <= 8'h00;
         cvld_reg <= 1'b0;
         stim_reg <= 8'h00;
         ctl1_reg <= 8'h07;
         dest_reg <= 8'h00;
         stc_reg <= 16'h0000;
         int_reg <= 6'h00;
         wp_reg <= 4'h0;
         rp_reg <= 4'h0;
         fcnt_reg <= 5'h00;
      end else begin
         hr_reg <= hr_next;
         wpend_reg <= wpend_next;
         wa_reg <= wa_next;
         cmd_reg <= cmd_next;
         cvld_reg <= cvld_next;
         stim_reg <= stim_next;
         ctl1_reg <= ctl1_next;
         dest_reg <= dest_next;
         stc_reg <= stc_next;
         int_reg <= int_next;
         wp_reg <= wp_next;
         rp_reg <= rp_next;
         fcnt_reg <= fcnt_next;
      end
      if (mem_we) begin
         mem[wp_reg] <= seq_push ? dbi : HWDATA[7:0];
      end
   end

   // Selection, message and command sequencer
   always_comb begin
      st_next = st_reg;
      cnt_next = cnt_reg;
      tmo_next = tmo_reg;
      msg_next = msg_reg;
      ctc_next = ctc_reg;
      oe_next = oe_reg;
      dbo_next = dbo_reg;
      dboe_next = dboe_reg;
      armed_next = armed_reg;
      stop_next = stop_reg;
      ti_next = ti_reg;
      resel_next = resel_reg;
      dmav_next = 1'b0;
      dmad_next = dmad_reg;
      tick_next = tick ? 16'h0000 : tick_reg + 16'h0001;
      int_set = 6'h00;
      cmd_take = 1'b0;
      clr_req = 1'b0;
      seq_pop = 1'b0;
      seq_push = 1'b0;
      case (st_reg)
         ssg_pkg::S_IDLE: begin
            if (sel_det) begin
               oe_next[`SSG_BSY] = 1'b0;
               resel_next = ctl[`SSG_IO];
               dmav_next = cmd_reg[`SSG_CMD_DMA_BIT];
               dmad_next = dbi;
               seq_push = !cmd_reg[`SSG_CMD_DMA_BIT];
               st_next = ssg_pkg::S_RESP;
            end
         end
         ssg_pkg::S_ARBW: begin
            if (!ctl[`SSG_BSY] && !ctl[`SSG_SEL]) begin
               oe_next[`SSG_BSY] = 1'b0;
               dbo_next = ~own_bit;
               dboe_next = 1'b0;
               cnt_next = 8'(`SSG_ARB_CYC);
               st_next = ssg_pkg::S_ARB;
            end
         end
         ssg_pkg::S_ARB: begin
            if (cnt_reg != 8'h00) begin
               cnt_next = cnt_reg - 8'h01;
            end else if (((dbi & higher) != 8'h00) || ctl[`SSG_SEL]) begin
               // Lost: back off and wait for bus free again
               oe_next = 8'hff;
               dboe_next = 1'b1;
               st_next = ssg_pkg::S_ARBW;
            end else begin
               oe_next[`SSG_SEL] = 1'b0;
               oe_next[`SSG_ATN] = 1'b0;
               dbo_next = ~(own_bit | (8'h01 << dest_reg[2:0]));
               cnt_next = 8'(`SSG_SETTLE_CYC);
               st_next = ssg_pkg::S_SELD;
            end
         end
         ssg_pkg::S_SELD: begin
            if (cnt_reg != 8'h00) begin
               cnt_next = cnt_reg - 8'h01;
            end else begin
               oe_next[`SSG_BSY] = 1'b1;
               tmo_next = stim_reg;
               cnt_next = 8'(`SSG_FLUSH_CYC);
               st_next = ssg_pkg::S_SELW;
            end
         end
         ssg_pkg::S_SELW: begin
            // Own BSY still shows through the synchronisers just after release
            if (cnt_reg != 8'h00) begin
               cnt_next = cnt_reg - 8'h01;
            end
            if (cnt_reg == 8'h00 && ctl[`SSG_BSY]) begin
               oe_next[`SSG_SEL] = 1'b1;
               dboe_next = 1'b1;
               st_next = ssg_pkg::S_XREQ;
            end else if (tick) begin
               if (tmo_reg == 8'h00) begin
                  oe_next = 8'hff;
                  dboe_next = 1'b1;
                  int_set[`SSG_INT_DISC] = 1'b1;
                  st_next = ssg_pkg::S_IDLE;
               end else begin
                  tmo_next = tmo_reg - 8'h01;
               end
            end
         end
         ssg_pkg::S_XREQ: begin
            if (!ctl[`SSG_BSY]) begin
               oe_next = 8'hff;
               dboe_next = 1'b1;
               armed_next = 1'b0;
               int_set[`SSG_INT_DISC] = 1'b1;
               st_next = ssg_pkg::S_IDLE;
            end else if (ctl[`SSG_REQ]) begin
               if (ctc_reg == 16'h0000) begin
                  int_set[`SSG_INT_SUCC] = !ti_reg;
                  int_set[`SSG_INT_SREQ] = 1'b1;
                  ti_next = 1'b0;
                  st_next = ssg_pkg::S_CONN;
               end else if (phase != (exp_msg ? `SSG_PH_MSGOUT : `SSG_PH_CMD)) begin
                  int_set[`SSG_INT_SREQ] = 1'b1;
                  ti_next = 1'b0;
                  msg_next = 2'h0;
                  st_next = ssg_pkg::S_CONN;
               end else begin
                  dbo_next = ~mem[rp_reg];
                  dboe_next = 1'b0;
                  seq_pop = 1'b1;
                  ctc_next = ctc_reg - 16'h0001;
                  // Attention drops before the last message byte is acknowledged, except on select-and-stop where it stays asserted
                  if (ti_reg ? (ctc_reg == 16'h0001) : (msg_reg == 2'h1 && !stop_reg)) begin
                     oe_next[`SSG_ATN] = 1'b1;
                  end
                  cnt_next = 8'(`SSG_SETTLE_CYC);
                  st_next = ssg_pkg::S_XACK;
               end
            end
         end
         ssg_pkg::S_XACK: begin
            if (cnt_reg != 8'h00) begin
               cnt_next = cnt_reg - 8'h01;
            end else if (oe_reg[`SSG_ACK]) begin
               oe_next[`SSG_ACK] = 1'b0;
            end else if (!ctl[`SSG_REQ]) begin
               oe_next[`SSG_ACK] = 1'b1;
               dboe_next = 1'b1;
               msg_next = (msg_reg != 2'h0) ? msg_reg - 2'h1 : 2'h0;
               if (stop_reg && msg_reg != 2'h0) begin
                  stop_next = 1'b0;
                  int_set[`SSG_INT_SUCC] = 1'b1;
                  st_next = ssg_pkg::S_CONN;
               end else begin
                  st_next = ssg_pkg::S_XREQ;
               end
            end
         end
         ssg_pkg::S_CONN: begin
            if (disc) begin
               oe_next = 8'hff;
               dboe_next = 1'b1;
               armed_next = 1'b0;
               int_set[`SSG_INT_DISC] = 1'b1;
               st_next = ssg_pkg::S_IDLE;
            end
         end
         ssg_pkg::S_RESP: begin
            if (!ctl[`SSG_SEL]) begin
               oe_next[`SSG_BSY] = 1'b1;
               int_set[resel_reg ? `SSG_INT_RESEL : `SSG_INT_SELD] = 1'b1;
               st_next = ssg_pkg::S_CONN;
            end
         end
         default: st_next = ssg_pkg::S_IDLE;
      endcase
      // Command dispatch; bit 7 picks the DMA form
      if (cmd_ok) begin
         cmd_take = 1'b1;
         case (op)
            `SSG_CMD_NOP: begin
               if (cmd_reg[`SSG_CMD_DMA_BIT]) begin
                  ctc_next = stc_reg;
               end
            end
            `SSG_CMD_CLRF: clr_req = 1'b1;
            `SSG_CMD_XFER: begin
               if (st_reg == ssg_pkg::S_CONN && !oe_reg[`SSG_ATN]) begin
                  ctc_next = cmd_reg[`SSG_CMD_DMA_BIT] ? stc_reg : {11'h000, fcnt_reg};
                  ti_next = 1'b1;
                  st_next = ssg_pkg::S_XREQ;
               end
            end
            `SSG_CMD_SELA, `SSG_CMD_SELS, `SSG_CMD_SEL3, `SSG_CMD_ENSEL, `SSG_CMD_DISSEL: begin
               if (st_reg == ssg_pkg::S_CONN) begin
                  int_set[`SSG_INT_INV] = 1'b1;
               end else if (op == `SSG_CMD_ENSEL) begin
                  armed_next = 1'b1;
               end else if (op == `SSG_CMD_DISSEL) begin
                  armed_next = 1'b0;
                  int_set[`SSG_INT_SUCC] = 1'b1;
               end else begin
                  ctc_next = cmd_reg[`SSG_CMD_DMA_BIT] ? stc_reg : {11'h000, fcnt_reg};
                  msg_next = (op == `SSG_CMD_SEL3) ? 2'h3 : 2'h1;
                  stop_next = (op == `SSG_CMD_SELS);
                  st_next = ssg_pkg::S_ARBW;
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         st_reg <= ssg_pkg::S_IDLE;
         cnt_reg <= 8'h00;
         tmo_reg <= 8'h00;
         msg_reg <= 2'h0;
         ctc_reg <= 16'h0000;
         oe_reg <= 8'hff;
         dbo_reg <= 8'hff;
         dboe_reg <= 1'b1;
         armed_reg <= 1'b0;
         stop_reg <= 1'b0;
         ti_reg <= 1'b0;
         resel_reg <= 1'b0;
         dmav_reg <= 1'b0;
         dmad_reg <= 8'h00;
         tick_reg <= 16'h0000;
      end else begin
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         tmo_reg <= tmo_next;
         msg_reg <= msg_next;
         ctc_reg <= ctc_next;
         oe_reg <= oe_next;
         dbo_reg <= dbo_next;
         dboe_reg <= dboe_next;
         armed_reg <= armed_next;
         stop_reg <= stop_next;
         ti_reg <= ti_next;
         resel_reg <= resel_next;
         dmav_reg <= dmav_next;
         dmad_reg <= dmad_next;
         tick_reg <= tick_next;
      end
   end

   // Outputs straight from flops or tied constants; open-drain lines only ever pull low
   assign HRDATA = hr_reg;
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   assign SCSI_CTL_OUT = 8'h00;
   assign SCSI_CTL_OE_N = oe_reg;
   assign SCSI_DB_OUT = dbo_reg;
   assign SCSI_DB_OE_N = dboe_reg;
   assign DMA_RX_VALID = dmav_reg;
   assign DMA_RX_DATA = dmad_reg;

   // Checks
   property p_sel_atn;
      @(posedge REF_CLK) disable iff (SRST) $fell(oe_reg[`SSG_SEL]) |-> !oe_reg[`SSG_ATN];
   endproperty
   a_sel_atn: assert property (p_sel_atn) else $error("selection without attention");
   property p_tmo;
      @(posedge REF_CLK) disable iff (SRST)
         (st_reg == ssg_pkg::S_SELW && tick && tmo_reg == 8'h00 && !ctl[`SSG_BSY]) |=> st_reg == ssg_pkg::S_IDLE && oe_reg == 8'hff;
   endproperty
   a_tmo: assert property (p_tmo) else $error("timeout did not end select");
   property p_stop_atn;
      @(posedge REF_CLK) disable iff (SRST)
         (st_reg == ssg_pkg::S_XACK && stop_reg && st_next == ssg_pkg::S_CONN) |=> !oe_reg[`SSG_ATN] ##1 !oe_reg[`SSG_ATN];
   endproperty
   a_stop_atn: assert property (p_stop_atn) else $error("attention dropped after stop");
   property p_ti_atn;
      @(posedge REF_CLK) disable iff (SRST) (st_reg == ssg_pkg::S_XREQ && ti_reg && ctc_reg > 16'h0001) |-> !oe_reg[`SSG_ATN];
   endproperty
   a_ti_atn: assert property (p_ti_atn) else $error("attention dropped with count left");
   property p_disarm;
      @(posedge REF_CLK) disable iff (SRST) int_set[`SSG_INT_DISC] && st_reg != ssg_pkg::S_SELW |=> !armed_reg;
   endproperty
   a_disarm: assert property (p_disarm) else $error("still armed after disconnect");
   property p_dis;
      @(posedge REF_CLK) disable iff (SRST)
         (cmd_ok && op == `SSG_CMD_DISSEL && st_reg == ssg_pkg::S_IDLE) |=> !armed_reg && int_reg[`SSG_INT_SUCC];
   endproperty
   a_dis: assert property (p_dis) else $error("disable did not disarm");
   property p_hold;
      @(posedge REF_CLK) disable iff (SRST) (st_reg == ssg_pkg::S_RESP)[*2] |-> !cvld_reg && cmd_reg == 8'h00;
   endproperty
   a_hold: assert property (p_hold) else $error("command accepted during selection");
   property p_nop_dma;
      @(posedge REF_CLK) disable iff (SRST) (cmd_ok && cmd_reg == 8'h80) |=> ctc_reg == $past(stc_reg) && !cvld_reg;
   endproperty
   a_nop_dma: assert property (p_nop_dma) else $error("count not copied");
   property p_clr;
      @(posedge REF_CLK) disable iff (SRST) (cmd_ok && op == `SSG_CMD_CLRF) |=> fcnt_reg == 5'h00 && rp_reg == 4'h0;
   endproperty
   a_clr: assert property (p_clr) else $error("FIFO not emptied");
   property p_inv;
      @(posedge REF_CLK) disable iff (SRST)
         (cmd_ok && st_reg == ssg_pkg::S_CONN && op[6:4] == 3'h4 && op[3:0] < 4'h7) |=> int_reg[`SSG_INT_INV] && st_reg != ssg_pkg::S_ARBW;
   endproperty
   a_inv: assert property (p_inv) else $error("connected idle command not refused");
   c_sel_done: cover property (@(posedge REF_CLK) disable iff (SRST) int_set[`SSG_INT_SUCC] && st_reg == ssg_pkg::S_XREQ);
   c_stop: cover property (@(posedge REF_CLK) disable iff (SRST) st_reg == ssg_pkg::S_XACK && st_next == ssg_pkg::S_CONN);
   c_resp: cover property (@(posedge REF_CLK) disable iff (SRST) st_reg == ssg_pkg::S_RESP ##1 st_reg == ssg_pkg::S_CONN);
endmodule : ssg_top

/* File: testbench/ssg_tgt.sv */
// Behavioural SCSI target: answers selection, takes message and command bytes.
// Assumes active-low open-drain lines resolved by the bench from both pull sets.
`timescale 1ns/1ns
module ssg_tgt #(
   parameter int ID = 3,
   parameter int NCMD = 2
) (
   // Clock, enable and bus levels
   input wire logic clk,
   input wire logic on,
   input wire logic [7:0] ctl,
   input wire logic [7:0] db,
   // Lines this target pulls low
   output logic [7:0] pull
);
   logic [7:0] got[$];
   int i;
   // One REQ/ACK byte; REQ dropped only after ACK seen, as a real target would
   task automatic xfer();
      @(posedge clk) pull[4] <= 1'b1;
      wait (ctl[3] === 1'b0);
      got.push_back(~db);
      @(posedge clk) pull[4] <= 1'b0;
      wait (ctl[3] === 1'b1);
   endtask : xfer
   // Message-out while attention held, command bytes, then status and bus release
   initial begin
      pull = 8'h00;
      forever begin
         @(posedge clk);
         if (on && ctl[1] === 1'b0 && db[ID] === 1'b0) begin
            repeat (3) @(posedge clk);
            pull[0] <= 1'b1;
            wait (ctl[1] === 1'b1);
            @(posedge clk) pull[7:5] <= 3'b011;
            while (ctl[2] === 1'b0) xfer();
            pull[7:5] <= 3'b010;
            for (i = 0; i < NCMD; i++) xfer();
            @(posedge clk) pull[7:5] <= 3'b110;
            pull[4] <= 1'b1;
            repeat (40) @(posedge clk);
            pull <= 8'h00;
         end
      end
   end
endmodule : ssg_tgt

/* File: testbench/testbench.sv */
// Self-checking bench: register traffic, select runs, general commands.
// Assumes the target model stands on the far side of the SCSI lines.
`timescale 1ns/1ns
`include "ssg_defs.svh"
module testbench;
   logic clk, srst, hsel, hwrite, hrdy, db_oe_n, on;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [7:0] oe_n, db_out, pull;
   logic [7:0] exp[$];
   int err_total = 0, compares = 0, seed = 83657, k;
   // Lines low when either side pulls; released data bus floats high
   wire logic [7:0] ctl_in = oe_n & ~pull;
   wire logic [7:0] db_in = db_oe_n ? 8'hff : db_out;
   ssg_top #(.TICK_CYC(4)) i_ssg_top (.REF_CLK(clk), .SRST(srst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy), .HRDATA(hrdata), .HREADYOUT(hrdy),
      .HRESP(), .SCSI_CTL_IN(ctl_in), .SCSI_CTL_OUT(), .SCSI_CTL_OE_N(oe_n), .SCSI_DB_IN(db_in),
      .SCSI_DB_OUT(db_out), .SCSI_DB_OE_N(db_oe_n), .DMA_RX_VALID(), .DMA_RX_DATA());
   ssg_tgt #(.ID(3), .NCMD(2)) i_ssg_tgt (.clk(clk), .on(on), .ctl(ctl_in), .db(db_in), .pull(pull));
   // One single AHB transfer; read data left in r
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hwrite <= w;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hsel <= 1'b1;
      @(posedge clk);
      while (hrdy !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hrdy !== 1'b1) @(posedge clk);
      r = hrdata;
   endtask : bus
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         err_total++;
         $display("[FAIL] %s exp %h got %h", n, e, s);
      end
   endtask : chk
   task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(n, r, e);
   endtask : rd
   // Preload messages plus two command bytes, select, compare bytes and status
   task automatic sel(input logic [7:0] c, input int n);
      for (k = 0; k < n + 2; k++) begin
         exp.push_back(8'($random(seed)));
         bus(1'b1, `SSG_OFS_FIFO, {24'h0, exp[k]});
      end
      bus(1'b1, `SSG_OFS_CMD, {24'h0, c});
      k = 0;
      while ((i_ssg_tgt.got.size() < n + 2 || ctl_in[0] !== 1'b1) && k < 5000) begin
         @(posedge clk);
         k++;
      end
      if (k == 5000) err_total++;
      repeat (4) @(posedge clk);
      for (k = 0; k < n + 2; k++) chk("byte", {24'h0, i_ssg_tgt.got[k]}, {24'h0, exp[k]});
      rd("status", `SSG_OFS_STAT, 32'h0b);
      rd("flags", `SSG_OFS_FLAGS, 32'h0);
      exp.delete();
      i_ssg_tgt.got.delete();
      $display("select %h done", c);
   endtask : sel
   task automatic end_sim();
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_sim
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Hang guard, well beyond the longest select plus timeout
   initial begin
      repeat (30000) @(posedge clk);
      err_total++;
      end_sim();
   end
   initial begin
      {hsel, hwrite, on, srst} = 4'b0001;
      htrans = 2'h0;
      haddr = 32'h0;
      hwdata = 32'h0;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      rd("ctl1", `SSG_OFS_CTL1, 32'h7);
      rd("state", `SSG_OFS_STATE, 32'h0);
      bus(1'b1, `SSG_OFS_STIM, 32'h10);
      bus(1'b1, `SSG_OFS_CTL1, 32'h7);
      bus(1'b1, `SSG_OFS_DEST, 32'h3);
      bus(1'b1, `SSG_OFS_CMD, 32'h44);
      on <= 1'b1;
      sel(8'h42, 1);
      rd("disarm", `SSG_OFS_STATE, 32'h0);
      // Rearm soon after the disconnect, then disarm before any selection
      bus(1'b1, `SSG_OFS_CMD, 32'h44);
      repeat (2) @(posedge clk);
      rd("rearm", `SSG_OFS_STATE, 32'h100);
      bus(1'b1, `SSG_OFS_CMD, 32'h45);
      repeat (2) @(posedge clk);
      rd("dis", `SSG_OFS_STATE, 32'h0);
      rd("dis int", `SSG_OFS_STAT, 32'h1);
      sel(8'h46, 3);
      // DMA no-operation: count copied, no interrupt
      k = $random(seed);
      bus(1'b1, `SSG_OFS_STC, {16'h0, k[15:0]});
      bus(1'b1, `SSG_OFS_CMD, 32'h80);
      repeat (2) @(posedge clk);
      rd("ctc", `SSG_OFS_CTC, {16'h0, k[15:0]});
      rd("nop int", `SSG_OFS_STAT, 32'h0);
      // Absent target: select-and-stop must time out
      on <= 1'b0;
      bus(1'b1, `SSG_OFS_FIFO, 32'h5a);
      bus(1'b1, `SSG_OFS_CMD, 32'h43);
      r = 32'h0;
      for (k = 0; k < 1000 && r === 32'h0; k++) bus(1'b0, `SSG_OFS_STAT, 32'h0);
      chk("timeout", r, 32'h8);
      bus(1'b1, `SSG_OFS_FIFO, 32'h33);
      bus(1'b1, `SSG_OFS_CMD, 32'h01);
      repeat (2) @(posedge clk);
      rd("flags", `SSG_OFS_FLAGS, 32'h0);
      rd("clr int", `SSG_OFS_STAT, 32'h0);
      $display("general commands done");
      // Select-and-stop, refused select while connected, then one more message
      on <= 1'b1;
      exp.push_back(8'($random(seed)));
      exp.push_back(8'($random(seed)));
      bus(1'b1, `SSG_OFS_FIFO, {24'h0, exp[0]});
      bus(1'b1, `SSG_OFS_CMD, 32'h43);
      for (k = 0; k < 5000 && i_ssg_tgt.got.size() < 1; k++) @(posedge clk);
      repeat (20) @(posedge clk);
      rd("stop int", `SSG_OFS_STAT, 32'h1);
      chk("stop atn", {31'h0, ctl_in[2]}, 32'h0);
      bus(1'b1, `SSG_OFS_CMD, 32'h42);
      repeat (2) @(posedge clk);
      rd("inv int", `SSG_OFS_STAT, 32'h4);
      bus(1'b1, `SSG_OFS_FIFO, {24'h0, exp[1]});
      bus(1'b1, `SSG_OFS_CMD, 32'h10);
      for (k = 0; k < 5000 && i_ssg_tgt.got.size() < 2; k++) @(posedge clk);
      repeat (20) @(posedge clk);
      for (k = 0; k < 2; k++) chk("msg", {24'h0, i_ssg_tgt.got[k]}, {24'h0, exp[k]});
      chk("ti atn", {31'h0, ctl_in[2]}, 32'h1);
      rd("ti int", `SSG_OFS_STAT, 32'h2);
      $display("stop and transfer done");
      end_sim();
   end
endmodule : testbench
